// ==== inc/ucd_pkg.sv ====
// Constants and types for the CTS delta, scratch and low-power divisor block.
// Assumes a 32-bit APB master on pclk and an asynchronous cts_n pin.
package ucd_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [31:0] UCD_MLS_ADDR = 32'h5000_1118;
  localparam logic [31:0] UCD_SCR_ADDR = 32'h5000_111C;
  localparam logic [31:0] UCD_LPL_ADDR = 32'h5000_1120;
  localparam logic [31:0] UCD_LPH_ADDR = 32'h5000_1124;
  localparam logic [31:0] UCD_CTRL_ADDR = 32'h5000_11F0;

  localparam logic [31:0] UCD_ZERO_WORD = 32'h0000_0000;
  localparam logic [7:0] UCD_BYTE_RESET = 8'h00;
  localparam int UCD_BYTE_W = 8;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int UCD_MLS_DELTA_POS = 0;
  localparam int UCD_MLS_CTS_POS = 4;
  localparam int UCD_CTRL_RTS_POS = 1;
  localparam int UCD_CTRL_LOOP_POS = 4;
  localparam int UCD_CTRL_DACC_POS = 7;
  localparam int UCD_CTRL_SRST_POS = 0;

  // ****************************************************************
  // Low-power baud divider
  // ****************************************************************
  localparam int UCD_DIV_W = 16;
  localparam logic [3:0] UCD_PRESCALE_LAST = 4'hF;
  localparam logic [3:0] UCD_PRESCALE_ZERO = 4'h0;
  localparam logic [15:0] UCD_DIV_ZERO = 16'h0000;
  localparam logic [15:0] UCD_DIV_ONE = 16'h0001;
  localparam int UCD_PRESCALE = 16;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic div_access;
    logic loopback;
    logic rts;
  } ucd_ctrl_type;

  localparam ucd_ctrl_type UCD_CTRL_RESET = '{1'b0, 1'b0, 1'b0};

  typedef enum {
    UCD_SEL_MLS,
    UCD_SEL_SCR,
    UCD_SEL_LPL,
    UCD_SEL_LPH,
    UCD_SEL_CTRL,
    UCD_SEL_LOCKED,
    UCD_SEL_NONE
  } ucd_sel_type;

endpackage : ucd_pkg

// ==== rtl/ucd_uart_lp.sv ====
// CTS delta flag, scratch byte, low-power divisor and its baud enable.
// Assumes an APB master on pclk; cts_n comes straight from a pin.
//
// What this block does
// - Delta flag set when CTS changed since read.
// - Reading modem status clears the delta flag.
// - Loopback makes delta follow the RTS bit.
// - CTS low through reset sets flag after.
// - Scratch byte is plain storage, no effect.
// - Two bytes form the 16-bit low-power divisor.
// - Divisor bytes reachable only with access bit set.
// - Baud enable every sixteen times divisor cycles.
// - Receiver pulse detection uses the baud enable.
// - Zero divisor stops baud enable and detection.
// - CTS status bit is complement of cts_n, or the RTS bit in loopback.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps

module ucd_uart_lp
  import ucd_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Modem pin.
  input wire logic cts_n,
  // Towards the receiver.
  output logic lp_baud_tick,
  output logic lp_detect_en,
  output logic [15:0] lp_divisor
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic ucd_sel_type decode(input logic [31:0] addr,
                                         input logic div_access);
    ucd_sel_type sel;
    sel = UCD_SEL_NONE;
    case (addr)
      UCD_MLS_ADDR: sel = UCD_SEL_MLS;
      UCD_SCR_ADDR: sel = UCD_SEL_SCR;
      UCD_LPL_ADDR: sel = div_access ? UCD_SEL_LPL : UCD_SEL_LOCKED;
      UCD_LPH_ADDR: sel = div_access ? UCD_SEL_LPH : UCD_SEL_LOCKED;
      UCD_CTRL_ADDR: sel = UCD_SEL_CTRL;
      default: sel = UCD_SEL_NONE;
    endcase
    return sel;
  endfunction : decode

  ucd_ctrl_type ctrl_ff;
  ucd_sel_type sel;
  logic setup;
  logic access;
  logic wr_en;
  logic rd_en;
  logic soft_rst;
  logic [7:0] scratch_ff;
  logic [7:0] div_low_ff;
  logic [7:0] div_high_ff;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;

  assign sel = decode(paddr, ctrl_ff.div_access);
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign pslverr = access && (sel == UCD_SEL_NONE);
  assign wr_en = access && pwrite && (sel != UCD_SEL_NONE);
  assign rd_en = access && !pwrite;
  assign soft_rst = wr_en && (sel == UCD_SEL_CTRL) &&
                    pwdata[UCD_CTRL_SRST_POS];
  assign prdata = prdata_ff;

  // ****************************************************************
  // CTS pin synchroniser
  // ****************************************************************
  // Stages reset to the idle level so that a line held low through
  // reset is seen as a change once reset lifts.
  logic cts_n_s1_ff;
  logic cts_n_s2_ff;
  logic cts_n_s3_ff;
  logic cts_n_stable_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_n_s1_ff <= 1'b1;
      cts_n_s2_ff <= 1'b1;
      cts_n_s3_ff <= 1'b1;
    end else begin
      cts_n_s1_ff <= cts_n;
      cts_n_s2_ff <= cts_n_s1_ff;
      cts_n_s3_ff <= cts_n_s2_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_n_stable_ff <= 1'b1;
    end else if (soft_rst) begin
      cts_n_stable_ff <= 1'b1;
    end else if (cts_n_s2_ff == cts_n_s3_ff) begin
      cts_n_stable_ff <= cts_n_s3_ff;
    end
  end

  // ****************************************************************
  // Delta clear-to-send
  // ****************************************************************
  logic cts_level;
  logic level_prev_ff;
  logic changed;
  logic status_read;
  logic dcts_ff;
  logic nxt_dcts;

  assign cts_level = ctrl_ff.loopback ? ctrl_ff.rts :
                     !cts_n_stable_ff;
  assign changed = (cts_level != level_prev_ff);
  assign status_read = rd_en && (sel == UCD_SEL_MLS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_prev_ff <= 1'b0;
    end else if (soft_rst) begin
      level_prev_ff <= 1'b0;
    end else begin
      level_prev_ff <= cts_level;
    end
  end

  // Only a flag that the read actually returned is cleared, so a
  // change landing between setup and access is kept.
  always_comb begin
    nxt_dcts = dcts_ff;
    if (status_read && prdata_ff[UCD_MLS_DELTA_POS]) begin
      nxt_dcts = 1'b0;
    end
    if (changed) begin
      nxt_dcts = 1'b1;
    end
    if (soft_rst) begin
      nxt_dcts = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcts_ff <= 1'b0;
    end else begin
      dcts_ff <= nxt_dcts;
    end
  end

  // ****************************************************************
  // Control, scratch and divisor registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= UCD_CTRL_RESET;
    end else if (wr_en && sel == UCD_SEL_CTRL) begin
      ctrl_ff.div_access <= pwdata[UCD_CTRL_DACC_POS];
      ctrl_ff.loopback <= pwdata[UCD_CTRL_LOOP_POS];
      ctrl_ff.rts <= pwdata[UCD_CTRL_RTS_POS];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scratch_ff <= UCD_BYTE_RESET;
    end else if (wr_en && sel == UCD_SEL_SCR) begin
      scratch_ff <= pwdata[UCD_BYTE_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_low_ff <= UCD_BYTE_RESET;
      div_high_ff <= UCD_BYTE_RESET;
    end else if (wr_en && sel == UCD_SEL_LPL) begin
      div_low_ff <= pwdata[UCD_BYTE_W-1:0];
    end else if (wr_en && sel == UCD_SEL_LPH) begin
      div_high_ff <= pwdata[UCD_BYTE_W-1:0];
    end
  end

  assign lp_divisor = {div_high_ff, div_low_ff};

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Read data is captured in the setup cycle so prdata is a flop.
  always_comb begin
    nxt_prdata = UCD_ZERO_WORD;
    case (sel)
      UCD_SEL_MLS: begin
        nxt_prdata[UCD_MLS_DELTA_POS] = dcts_ff;
        nxt_prdata[UCD_MLS_CTS_POS] = cts_level;
      end
      UCD_SEL_SCR: nxt_prdata[UCD_BYTE_W-1:0] = scratch_ff;
      UCD_SEL_LPL: nxt_prdata[UCD_BYTE_W-1:0] = div_low_ff;
      UCD_SEL_LPH: nxt_prdata[UCD_BYTE_W-1:0] = div_high_ff;
      UCD_SEL_CTRL: begin
        nxt_prdata[UCD_CTRL_DACC_POS] = ctrl_ff.div_access;
        nxt_prdata[UCD_CTRL_LOOP_POS] = ctrl_ff.loopback;
        nxt_prdata[UCD_CTRL_RTS_POS] = ctrl_ff.rts;
      end
      default: nxt_prdata = UCD_ZERO_WORD;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= UCD_ZERO_WORD;
    end else if (setup && !pwrite) begin
      prdata_ff <= nxt_prdata;
    end
  end

  // ****************************************************************
  // Low-power baud enable
  // ****************************************************************
  // A divisor write restarts the count; the receiver still needs
  // some slow cycles to settle, which is left to software.
  logic div_zero;
  logic div_write;
  logic [3:0] pre_ff;
  logic [15:0] div_cnt_ff;
  logic tick_ff;
  logic detect_en_ff;

  assign div_zero = (lp_divisor == UCD_DIV_ZERO);
  assign div_write = wr_en && (sel == UCD_SEL_LPL || sel == UCD_SEL_LPH);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= UCD_PRESCALE_ZERO;
      div_cnt_ff <= UCD_DIV_ZERO;
      tick_ff <= 1'b0;
    end else if (div_zero || div_write) begin
      pre_ff <= UCD_PRESCALE_ZERO;
      div_cnt_ff <= UCD_DIV_ZERO;
      tick_ff <= 1'b0;
    end else if (pre_ff == UCD_PRESCALE_LAST) begin
      pre_ff <= UCD_PRESCALE_ZERO;
      if (div_cnt_ff == lp_divisor - UCD_DIV_ONE) begin
        div_cnt_ff <= UCD_DIV_ZERO;
        tick_ff <= 1'b1;
      end else begin
        div_cnt_ff <= div_cnt_ff + UCD_DIV_ONE;
        tick_ff <= 1'b0;
      end
    end else begin
      pre_ff <= pre_ff + 4'h1;
      tick_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_en_ff <= 1'b0;
    end else begin
      detect_en_ff <= !div_zero;
    end
  end

  assign lp_baud_tick = tick_ff;
  assign lp_detect_en = detect_en_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Cycles since the last tick, armed once a full period has run
  // with no divisor write in between.
  logic [19:0] gap_ff;
  logic armed_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_ff <= 20'h00000;
      armed_ff <= 1'b0;
    end else begin
      gap_ff <= tick_ff ? 20'h00000 : gap_ff + 20'h00001;
      armed_ff <= (armed_ff || tick_ff) && !div_write && !div_zero;
    end
  end

  sequence s_soft_then_low;
    soft_rst ##1 (!cts_n_s3_ff && !cts_n_s2_ff && !ctrl_ff.loopback &&
                  !soft_rst)[*2];
  endsequence

  a_dcts_on_change: assert property (
    changed && !soft_rst |=> dcts_ff)
    else $error("delta flag missed a CTS change");

  a_dcts_read_clear: assert property (
    status_read && prdata_ff[UCD_MLS_DELTA_POS] && !changed |=> !dcts_ff)
    else $error("status read did not clear delta flag");

  a_loop_rts_delta: assert property (
    ctrl_ff.loopback && $past(ctrl_ff.loopback) && $changed(ctrl_ff.rts)
    && !soft_rst |=> dcts_ff)
    else $error("loopback RTS change not flagged");

  a_reset_cts_low: assert property (
    s_soft_then_low |=> dcts_ff)
    else $error("CTS held low over reset not flagged");

  a_scratch_hold: assert property (
    !(wr_en && sel == UCD_SEL_SCR) |=> $stable(scratch_ff))
    else $error("scratch byte changed without a write");

  a_div_locked: assert property (
    !ctrl_ff.div_access |=> $stable(lp_divisor))
    else $error("divisor changed with access bit clear");

  a_tick_period: assert property (
    tick_ff && armed_ff |->
    gap_ff == 20'(UCD_PRESCALE * lp_divisor - 1))
    else $error("baud enable period wrong");

  a_zero_div_idle: assert property (
    div_zero |=> !tick_ff && !detect_en_ff)
    else $error("zero divisor still enables detection");

  a_cts_status_bit: assert property (
    setup && !pwrite && sel == UCD_SEL_MLS |=>
    prdata_ff[UCD_MLS_CTS_POS] == $past(cts_level))
    else $error("CTS status bit wrong");

  a_upper_byte_zero: assert property (
    access && !pwrite |-> prdata_ff[31:UCD_BYTE_W] == 24'h000000)
    else $error("reserved upper bits not zero");

endmodule : ucd_uart_lp

// ==== test/ucd_modem_model.sv ====
// Modem model that drives the active-low clear-to-send pin.
// Assumes the bench sets the wanted level and a reaction lag in cycles.
`timescale 1ns/1ps

module ucd_modem_model (
  // Clock.
  input wire logic pclk,
  // Control from the bench.
  input wire logic want_ready,
  input wire logic [3:0] lag,
  // Modem pin.
  output logic cts_n
);
  // ********
  // Pin driver
  // ********
  // A slow modem answers late, so the pin is moved only after the lag.
  logic [3:0] cnt_ff;
  initial cts_n = 1'b1;
  initial cnt_ff = 4'h0;
  always @(posedge pclk) begin
    if (cts_n == want_ready) begin
      cnt_ff <= cnt_ff + 4'h1;
      if (cnt_ff >= lag) begin
        cts_n <= ~want_ready;
        cnt_ff <= 4'h0;
      end
    end else begin
      cnt_ff <= 4'h0;
    end
  end
endmodule : ucd_modem_model

// ==== test/tb_ucd_uart_lp.sv ====
// Self-checking bench for the CTS delta, scratch and divisor block.
// Assumes the block answers APB with pready and a modem model on cts_n.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e); end end

module tb_ucd_uart_lp
  import ucd_pkg::*;
;
  // ********
  // Signals
  // ********
  localparam int TMAX = 9000;
  // Nearest low-power divisor to 115.2K baud from the 10 MHz clock.
  localparam logic [15:0] DIV_115K = 16'h0005;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd, d;
  logic lp_baud_tick, lp_detect_en, cts_n, cts_want;
  logic [15:0] lp_divisor, dv;
  logic [3:0] lag;
  int mismatches, num_checks, n;

  ucd_uart_lp u_ucd_uart_lp (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cts_n(cts_n),
    .lp_baud_tick(lp_baud_tick), .lp_detect_en(lp_detect_en),
    .lp_divisor(lp_divisor));
  ucd_modem_model u_ucd_modem_model (.pclk(pclk), .want_ready(cts_want),
    .lag(lag), .cts_n(cts_n));

  // ********
  // Helpers
  // ********
  function automatic int exp_period(input logic [15:0] div);
    return UCD_PRESCALE * int'(div);
  endfunction : exp_period

  task automatic end_sim;
    $display("mismatches %0d num_checks %0d", mismatches, num_checks);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  task automatic hw_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : hw_reset

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, UCD_ZERO_WORD);
    `CHK(rd, e)
  endtask : chk_rd

  task automatic tick_gap(output int c);
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (lp_baud_tick !== 1'b1 && c < TMAX);
  endtask : tick_gap

  // ********
  // Clock and watchdog
  // ********
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    repeat (80000) @(posedge pclk);
    mismatches++;
    end_sim();
  end

  // ********
  // Tests
  // ********
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    cts_want = 1'b0;
    lag = 4'h0;
    mismatches = 0;
    num_checks = 0;
    void'($urandom(90452));
    hw_reset();
    `CHK(lp_divisor, UCD_DIV_ZERO)
    `CHK(lp_detect_en, 1'b0)
    chk_rd(UCD_MLS_ADDR, 32'h0);
    chk_rd(UCD_SCR_ADDR, 32'h0);
    apb(1'b1, UCD_CTRL_ADDR, 32'h80);
    chk_rd(UCD_LPL_ADDR, 32'h0);
    chk_rd(UCD_LPH_ADDR, 32'h0);
    apb(1'b0, 32'h5000_1128, UCD_ZERO_WORD);
    `CHK({err, rd}, {1'b1, 32'h0})
    repeat (4) begin
      d = $urandom;
      apb(1'b1, UCD_SCR_ADDR, d);
      chk_rd(UCD_SCR_ADDR, {24'h0, d[7:0]});
      `CHK(lp_divisor, UCD_DIV_ZERO)
    end
    for (int i = 0; i < 3; i++) begin
      d = $urandom;
      dv = (i == 2) ? {8'h01, d[7:0]} : {12'h000, {1'b0, d[2:0]} + 4'h1};
      if (i == 0) begin
        dv = DIV_115K;
      end
      apb(1'b1, UCD_LPL_ADDR, {d[31:8], dv[7:0]});
      apb(1'b1, UCD_LPH_ADDR, {d[31:8], dv[15:8]});
      repeat (8) @(posedge pclk);
      `CHK(lp_divisor, dv)
      `CHK(lp_detect_en, 1'b1)
      chk_rd(UCD_LPH_ADDR, {24'h0, dv[15:8]});
      tick_gap(n);
      tick_gap(n);
      `CHK(n, exp_period(dv))
    end
    // A nonzero high byte must stay hidden and unchanged while locked.
    apb(1'b1, UCD_CTRL_ADDR, 32'h00);
    apb(1'b1, UCD_LPH_ADDR, 32'h55);
    chk_rd(UCD_LPH_ADDR, 32'h0);
    `CHK(lp_divisor, dv)
    apb(1'b1, UCD_CTRL_ADDR, 32'h80);
    apb(1'b1, UCD_LPL_ADDR, 32'h0);
    apb(1'b1, UCD_LPH_ADDR, 32'h0);
    repeat (8) @(posedge pclk);
    `CHK(lp_detect_en, 1'b0)
    tick_gap(n);
    `CHK(n, TMAX)
    // A slow modem with a random lag moves the pin; the flag is read 20 cycles after the request.
    lag <= 4'($urandom % 8);
    cts_want <= 1'b1;
    repeat (20) @(posedge pclk);
    chk_rd(UCD_MLS_ADDR, 32'h11);
    chk_rd(UCD_MLS_ADDR, 32'h10);
    cts_want <= 1'b0;
    repeat (20) @(posedge pclk);
    chk_rd(UCD_MLS_ADDR, 32'h01);
    chk_rd(UCD_MLS_ADDR, 32'h00);
    apb(1'b1, UCD_CTRL_ADDR, 32'h10);
    chk_rd(UCD_MLS_ADDR, 32'h00);
    cts_want <= 1'b1;
    repeat (20) @(posedge pclk);
    chk_rd(UCD_MLS_ADDR, 32'h00);
    apb(1'b1, UCD_CTRL_ADDR, 32'h12);
    chk_rd(UCD_MLS_ADDR, 32'h11);
    chk_rd(UCD_MLS_ADDR, 32'h10);
    apb(1'b1, UCD_CTRL_ADDR, 32'h00);
    chk_rd(UCD_MLS_ADDR, 32'h10);
    hw_reset();
    repeat (10) @(posedge pclk);
    chk_rd(UCD_MLS_ADDR, 32'h11);
    chk_rd(UCD_MLS_ADDR, 32'h10);
    apb(1'b1, UCD_CTRL_ADDR, 32'h01);
    repeat (8) @(posedge pclk);
    chk_rd(UCD_MLS_ADDR, 32'h11);
    end_sim();
  end
endmodule : tb_ucd_uart_lp
